/* logic/clock_ref_output_config.sv */
// clock synthesizer configuration: reference muxes, drivers, crystal enables
`timescale 1ns/1ps
module clock_ref_output_config (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // serial register port
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    // one-time-programmable fuse contents
    input wire logic [23:0] fuse_ctrl_i,
    input wire logic [31:0] fuse_refbuf_i,
    input wire logic [15:0] fuse_fmt_i,
    input wire logic [15:0] fuse_second_crystal_force_i,
    // control pins
    input wire logic loop_a_powerdown_pin_n_i,
    input wire logic output_a_enable_pin_i,
    input wire logic output_b_enable_pin_i,
    input wire logic output_c_enable_pin_i,
    input wire logic output_d_enable_pin_i,
    input wire logic buffered_source_enable_pin_i,
    // synthesis loop controls
    output logic first_synth_loop_power_o,
    output logic second_synth_loop_power_o,
    output logic loop_a_source_select_o,
    output logic loop_b_source_select_o,
    // output drivers a..d (bit 0 = a) and their formats
    output logic [3:0] output_enable_o,
    output logic [7:0] output_format_o,
    // buffered reference driver
    output logic buffered_source_driver_enable_o,
    output logic [1:0] buffered_source_driver_format_o,
    output logic buffered_source_driver_select_o,
    // crystal oscillator amplifiers
    output logic first_crystal_amp_enable_o,
    output logic second_crystal_amp_enable_o
);
    // carrier between the serial port and the register file

    reg_access_if bus ();

    // configuration registers; narrow ones keep their low bits only
    // fuse images are sampled only in a load cycle, after reset or master reset
    logic [23:0] ctrl_r;      // output and reference control
    logic [31:0] refbuf_r;    // reference buffer config
    logic [15:0] fmt_r;       // output format and crystal setup
    logic [15:0] second_crystal_force_r;     // second crystal setup
    logic load_r;             // fuse load pending

    // enable pins gathered so that output n sits at bit n
    wire [3:0] pin_oe = {output_d_enable_pin_i, output_c_enable_pin_i,
                         output_b_enable_pin_i, output_a_enable_pin_i};
    wire [3:0] out_ovr;       // per-output pin override
    wire [3:0] out_reg_en;    // per-output register enable
    wire [3:0] out_on;        // requested state before loop gating
    wire [3:0] loop_on;       // feeding loop powered

    // per-output override decode
    for (genvar n = 0; n < 4; n++) begin : g_out
        assign out_ovr[n] = ctrl_r[clk_cfg_pkg::OUT_OVR_BASE + 2 * n];
        assign out_reg_en[n] = ctrl_r[clk_cfg_pkg::OUT_OVR_BASE + 2 * n + 1];
        // a set override makes the pin a don't-care, in either direction
        // register bit when overridden, pin otherwise
        assign out_on[n] = out_ovr[n] ? out_reg_en[n] : pin_oe[n];
    end

    // loop power: loop a may follow its powerdown pin, loop b is software only
    // a low powerdown pin takes loop a down unless software overrides it
    wire loop_a_pwr = ctrl_r[clk_cfg_pkg::LOOP_A_OVR_BIT]
                    ? ctrl_r[clk_cfg_pkg::LOOP_A_ON_BIT]
                    : loop_a_powerdown_pin_n_i;
    wire loop_b_pwr = ctrl_r[clk_cfg_pkg::LOOP_B_EN_BIT]
                    & ctrl_r[clk_cfg_pkg::LOOP_B_ON_BIT];
    // outputs a, b hang off loop a; c, d off loop b
    assign loop_on = {loop_b_pwr, loop_b_pwr, loop_a_pwr, loop_a_pwr};

    // reference choice per loop; crystal force bits play no part
    // a loop takes the second input only with enable and select both set
    wire src_a = ctrl_r[clk_cfg_pkg::SRC_A_EN_BIT]
               & ctrl_r[clk_cfg_pkg::SRC_A_SEL_BIT];
    wire src_b = ctrl_r[clk_cfg_pkg::SRC_B_EN_BIT]
               & ctrl_r[clk_cfg_pkg::SRC_B_SEL_BIT];
    // the driver mux bit picks the input of the buffered reference driver
    wire src_ref = refbuf_r[clk_cfg_pkg::REF_MUX_BIT];

    // buffered driver enable follows the same override scheme
    // it is not gated by loop power, since it buffers an input directly
    wire ref_on = ctrl_r[clk_cfg_pkg::REF_OVR_BIT]
                ? ctrl_r[clk_cfg_pkg::REF_ON_BIT]
                : buffered_source_enable_pin_i;

    // crystal amps: on when selected anywhere, or forced
    // a selection counts even when the selecting loop is powered down;
    // that costs some power but spares a crystal restart on power-up
    wire amp1 = ~src_a | ~src_b | ~src_ref
              | refbuf_r[clk_cfg_pkg::FIRST_CRYSTAL_FORCE_FORCE_BIT];
    wire amp2 = src_a | src_b | src_ref
              | second_crystal_force_r[clk_cfg_pkg::SECOND_CRYSTAL_FORCE_FORCE_BIT];

    // master reset request reloads the fuse image
    // the reload replaces the write, so the reset bits never read back set
    wire mr_req = bus.wr_stb && bus.addr == clk_cfg_pkg::IDX_CTRL
                && bus.wdata[clk_cfg_pkg::MR_EN_BIT]
                && bus.wdata[clk_cfg_pkg::MR_BIT];

    // read view: enable bits of pin-controlled outputs show the pins
    wire [23:0] ctrl_view;
    for (genvar n = 0; n < 4; n++) begin : g_view
        assign ctrl_view[clk_cfg_pkg::OUT_OVR_BASE + 2 * n] = out_ovr[n];
        assign ctrl_view[clk_cfg_pkg::OUT_OVR_BASE + 2 * n + 1] =
            out_ovr[n] ? out_reg_en[n] : pin_oe[n];
    end
    // bits above the reference controls always read zero
    assign ctrl_view[7:0] = ctrl_r[7:0];
    assign ctrl_view[23:16] = {4'h0, 2'h0, ctrl_r[17:16]};

    // word read mux, narrow registers in the low bits
    // unmapped indices read zero rather than any stale word
    assign bus.rdata =
        (bus.addr == clk_cfg_pkg::IDX_CTRL) ? {8'h00, ctrl_view} :
        (bus.addr == clk_cfg_pkg::IDX_REFBUF) ? refbuf_r :
        (bus.addr == clk_cfg_pkg::IDX_FMT) ? {16'h0000, fmt_r} :
        (bus.addr == clk_cfg_pkg::IDX_SECOND_CRYSTAL_FORCE) ? {16'h0000, second_crystal_force_r} :
        32'h0000_0000;

    // register file; fuses load on the cycle after reset or master reset
    // a write strobe landing in the load cycle is lost; the fuse image wins
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            load_r <= 1'b1;
            ctrl_r <= '0;
            refbuf_r <= '0;
            fmt_r <= '0;
            second_crystal_force_r <= '0;
        end else if (load_r) begin
            load_r <= 1'b0;
            ctrl_r <= fuse_ctrl_i;
            refbuf_r <= fuse_refbuf_i;
            fmt_r <= fuse_fmt_i;
            second_crystal_force_r <= fuse_second_crystal_force_i;
        end else if (mr_req) begin
            load_r <= 1'b1;
        end else if (bus.wr_stb) begin
            // master reset bits never stick; writes act next cycle
            if (bus.addr == clk_cfg_pkg::IDX_CTRL) begin
                ctrl_r <= {4'h0, 2'h0, bus.wdata[17:0]};
            end
            if (bus.addr == clk_cfg_pkg::IDX_REFBUF) begin
                refbuf_r <= bus.wdata;
            end
            if (bus.addr == clk_cfg_pkg::IDX_FMT) begin
                fmt_r <= bus.wdata[15:0];
            end
            if (bus.addr == clk_cfg_pkg::IDX_SECOND_CRYSTAL_FORCE) begin
                second_crystal_force_r <= bus.wdata[15:0];
            end
        end
    end

    // registered pin-facing outputs; all off while in reset
    // they follow the registers one cycle later, so every pin-facing signal
    // comes straight from a flop and cannot glitch on a decode change
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            first_synth_loop_power_o <= 1'b0;
            second_synth_loop_power_o <= 1'b0;
            loop_a_source_select_o <= 1'b0;
            loop_b_source_select_o <= 1'b0;
            output_enable_o <= '0;
            output_format_o <= '0;
            buffered_source_driver_enable_o <= 1'b0;
            buffered_source_driver_format_o <= clk_cfg_pkg::FMT_CMOS;
            buffered_source_driver_select_o <= 1'b0;
            first_crystal_amp_enable_o <= 1'b0;
            second_crystal_amp_enable_o <= 1'b0;
        end else begin
            first_synth_loop_power_o <= loop_a_pwr;
            second_synth_loop_power_o <= loop_b_pwr;
            loop_a_source_select_o <= src_a;
            loop_b_source_select_o <= src_b;
            // an output runs only while the loop feeding it is powered
            output_enable_o <= out_on & loop_on;
            // codes pass straight through: cmos, lvds, ecl, current steering
            output_format_o <= fmt_r[7:0];
            buffered_source_driver_enable_o <= ref_on;
            buffered_source_driver_format_o <=
                refbuf_r[clk_cfg_pkg::REF_FMT_LSB +: 2];
            buffered_source_driver_select_o <= src_ref;
            first_crystal_amp_enable_o <= amp1;
            second_crystal_amp_enable_o <= amp2;
        end
    end

    // serial port instance
    // the port samples sclk on clk_i, so sclk must stay well below clk_i
    serial_port u_port (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .sdi_i(sdi_i),
        .sdo_o(sdo_o),
        .bus(bus.port)
    );
endmodule : clock_ref_output_config

/* logic/clk_cfg_pkg.sv */
// constants shared by the clock configuration block and its serial port
package clk_cfg_pkg;
    // register word indices on the serial port (byte address = 4 x index)
    localparam logic [6:0] IDX_CTRL = 7'h02;
    localparam logic [6:0] IDX_REFBUF = 7'h03;
    localparam logic [6:0] IDX_FMT = 7'h04;
    localparam logic [6:0] IDX_SECOND_CRYSTAL_FORCE = 7'h0a;
    // register widths
    localparam int CTRL_W = 24;
    localparam int REFBUF_W = 32;
    localparam int FMT_W = 16;
    localparam int SECOND_CRYSTAL_FORCE_W = 16;
    // output and reference control fields
    localparam int LOOP_A_OVR_BIT = 0;
    localparam int LOOP_A_ON_BIT = 1;
    localparam int LOOP_B_EN_BIT = 2;
    localparam int LOOP_B_ON_BIT = 3;
    localparam int SRC_A_EN_BIT = 4;
    localparam int SRC_A_SEL_BIT = 5;
    localparam int SRC_B_EN_BIT = 6;
    localparam int SRC_B_SEL_BIT = 7;
    localparam int OUT_OVR_BASE = 8;  // override at 8+2n, enable at 9+2n
    localparam int REF_OVR_BIT = 16;
    localparam int REF_ON_BIT = 17;
    localparam int MR_EN_BIT = 18;
    localparam int MR_BIT = 19;
    // reference buffer config fields
    localparam int FIRST_CRYSTAL_FORCE_FORCE_BIT = 26;
    localparam int REF_MUX_BIT = 27;
    localparam int REF_FMT_LSB = 29;
    // second crystal force bit
    localparam int SECOND_CRYSTAL_FORCE_FORCE_BIT = 8;
    // output format codes
    localparam logic [1:0] FMT_CMOS = 2'h0;
    localparam logic [1:0] FMT_LVDS = 2'h1;
    localparam logic [1:0] FMT_ECL = 2'h2;
    localparam logic [1:0] FMT_CSTEER = 2'h3;
    // serial frame: command byte then one data word
    localparam int CMD_BITS = 8;
    localparam int DATA_BITS = 32;
endpackage : clk_cfg_pkg

/* logic/reg_access_if.sv */
// register access carrier between the serial port and the register file
`timescale 1ns/1ps
interface reg_access_if;
    logic wr_stb;        // one-cycle write strobe
    logic [6:0] addr;    // word index
    logic [31:0] wdata;  // write data
    logic [31:0] rdata;  // read data for addr
    modport port (output wr_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : reg_access_if

/* logic/serial_port.sv */
// serial register port: command byte (read flag, index) then 32 data bits
`timescale 1ns/1ps
module serial_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // serial pins, sampled on the system clock
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    // register side
    reg_access_if.port bus
);
    localparam int FRAME = clk_cfg_pkg::CMD_BITS + clk_cfg_pkg::DATA_BITS;

    logic sclk_q_r;           // previous sclk sample
    logic [5:0] cnt_r;        // bits received in this frame
    logic [30:0] sh_r;        // incoming shift register
    logic rd_r;               // frame is a read
    logic load_r;             // load read word next cycle
    logic [31:0] out_r;       // outgoing shift register
    logic [6:0] addr_r;
    logic wr_r;
    logic [31:0] wdata_r;

    // edges of the serial clock; sclk must be slower than clk_i / 4
    wire rise = sclk_i & ~sclk_q_r & ~cs_n_i;
    wire fall = ~sclk_i & sclk_q_r & ~cs_n_i;
    wire cmd_done = rise && cnt_r == 6'(clk_cfg_pkg::CMD_BITS - 1);
    wire frame_done = rise && cnt_r == 6'(FRAME - 1);

    assign bus.wr_stb = wr_r;
    assign bus.addr = addr_r;
    assign bus.wdata = wdata_r;

    // frame receive, command decode and write strobe
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sclk_q_r <= 1'b0;
            cnt_r <= '0;
            sh_r <= '0;
            rd_r <= 1'b0;
            load_r <= 1'b0;
            addr_r <= '0;
            wr_r <= 1'b0;
            wdata_r <= '0;
        end else begin
            sclk_q_r <= sclk_i;
            load_r <= cmd_done & sh_r[6];
            wr_r <= frame_done & ~rd_r;
            if (cs_n_i) begin
                // deselect aborts any partial frame
                cnt_r <= '0;
            end else if (rise) begin
                sh_r <= {sh_r[29:0], sdi_i};
                cnt_r <= frame_done ? '0 : cnt_r + 6'h01;
            end
            if (cmd_done) begin
                rd_r <= sh_r[6];
                addr_r <= {sh_r[5:0], sdi_i};
            end
            if (frame_done) begin
                wdata_r <= {sh_r, sdi_i};
            end
        end
    end

    // read data leaves msb first, changing on falling sclk
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            out_r <= '0;
            sdo_o <= 1'b0;
        end else if (load_r) begin
            out_r <= bus.rdata;
        end else if (fall && rd_r) begin
            sdo_o <= out_r[31];
            out_r <= {out_r[30:0], 1'b0};
        end
    end
endmodule : serial_port

/* verification/clock_ref_output_config_props.sv */
// assertion checker for the clock configuration block outputs
`timescale 1ns/1ps
module clock_ref_output_config_props (
    // clock, reset, serial select
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic cs_n_i,
    // loop and driver outputs
    input wire logic first_synth_loop_power_o,
    input wire logic second_synth_loop_power_o,
    input wire logic loop_a_source_select_o,
    input wire logic loop_b_source_select_o,
    input wire logic [3:0] output_enable_o,
    input wire logic [7:0] output_format_o,
    input wire logic buffered_source_driver_select_o,
    input wire logic first_crystal_amp_enable_o,
    input wire logic second_crystal_amp_enable_o
);
    // cycles since release; outputs settle on the fuse image two cycles later
    logic [1:0] up_r;
    always_ff @(posedge clk_i) begin
        up_r <= !reset_n_i ? 2'h0 : (up_r == 2'h3 ? up_r : up_r + 2'h1);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || up_r != 2'h3);
    // no serial frame for eight cycles, so no register can have moved
    sequence quiet_s;
        cs_n_i [*8];
    endsequence
    AST_LOOPA_GATE: assert property (
        |output_enable_o[1:0] |-> first_synth_loop_power_o)
        else $error("output a or b on with loop a down");
    AST_LOOPB_GATE: assert property (
        |output_enable_o[3:2] |-> second_synth_loop_power_o)
        else $error("output c or d on with loop b down");
    AST_FIRST_CRYSTAL_FORCE_AUTO: assert property (
        (!loop_a_source_select_o || !loop_b_source_select_o ||
        !buffered_source_driver_select_o) |-> first_crystal_amp_enable_o)
        else $error("first crystal off while selected");
    AST_SECOND_CRYSTAL_FORCE_AUTO: assert property (
        (loop_a_source_select_o || loop_b_source_select_o ||
        buffered_source_driver_select_o) |-> second_crystal_amp_enable_o)
        else $error("second crystal off while selected");
    AST_FMT_HOLD: assert property (
        quiet_s |=> $stable(output_format_o))
        else $error("format moved without a write");
    AST_SEL_HOLD: assert property (
        quiet_s |=> $stable({loop_a_source_select_o, loop_b_source_select_o}))
        else $error("source select moved without a write");
    AST_XTAL_HOLD: assert property (
        quiet_s |-> ##1 $stable(first_crystal_amp_enable_o) &&
        $stable(second_crystal_amp_enable_o))
        else $error("crystal enable moved without a write");
    AST_LOOPB_HOLD: assert property (
        quiet_s ##1 1'b1 |-> $stable(second_synth_loop_power_o))
        else $error("loop b power moved without a write");
endmodule : clock_ref_output_config_props
bind clock_ref_output_config clock_ref_output_config_props i_props (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i),
    .first_synth_loop_power_o(first_synth_loop_power_o),
    .second_synth_loop_power_o(second_synth_loop_power_o),
    .loop_a_source_select_o(loop_a_source_select_o),
    .loop_b_source_select_o(loop_b_source_select_o),
    .output_enable_o(output_enable_o), .output_format_o(output_format_o),
    .buffered_source_driver_select_o(buffered_source_driver_select_o),
    .first_crystal_amp_enable_o(first_crystal_amp_enable_o),
    .second_crystal_amp_enable_o(second_crystal_amp_enable_o));

/* verification/serial_host.sv */
// host model writing configuration words over the serial port
`timescale 1ns/1ps
module serial_host (
    // clock
    input wire logic clk_i,
    // serial pins
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    int half = 3;  // clk cycles per serial half period, raised for slow host
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // read flag, word index, then 32 data bits, all msb first; the word
    // returned by a read is taken from sdo at each data bit's rising sclk
    task automatic frame(input logic rd, input logic [6:0] idx,
        input logic [31:0] d, output logic [31:0] q);
        logic [39:0] f;
        f = {rd, idx, d};
        q = '0;
        @(negedge clk_i) cs_n_o = 1'b0;
        for (int i = 39; i >= 0; i--) begin
            sdi_o = f[i];
            repeat (half) @(negedge clk_i);
            sclk_o = 1'b1;
            if (i < 32) begin
                q = {q[30:0], sdo_i};
            end
            repeat (half) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;  // released line must not keep the last bit
        repeat (3) @(negedge clk_i);
    endtask : frame
endmodule : serial_host

/* verification/clock_ref_output_config_tb.sv */
// self-checking bench for the clock configuration block
`timescale 1ns/1ps
module clock_ref_output_config_tb;
    logic clk_i, reset_n_i, sclk, cs_n, sdi, sdo, loop_pin_n, ref_pin;
    logic [3:0] en_pin, oe;
    logic [23:0] fuse_c;
    logic [31:0] fuse_r;
    logic [15:0] fuse_f, fuse_x;
    logic la, lb, sla, slb, ren, rsel, x1, x2;
    logic [7:0] fmt;
    logic [1:0] rfmt;
    logic [21:0] act;
    int m_c, m_r, m_f, m_x;  // model registers
    int n_errors = 0, cmp_count = 0, cyc = 0;
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    serial_host i_host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(sdi), .sdo_i(sdo));
    clock_ref_output_config i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
        .fuse_ctrl_i(fuse_c), .fuse_refbuf_i(fuse_r),
        .fuse_fmt_i(fuse_f), .fuse_second_crystal_force_i(fuse_x),
        .loop_a_powerdown_pin_n_i(loop_pin_n),
        .output_a_enable_pin_i(en_pin[0]),
        .output_b_enable_pin_i(en_pin[1]),
        .output_c_enable_pin_i(en_pin[2]),
        .output_d_enable_pin_i(en_pin[3]),
        .buffered_source_enable_pin_i(ref_pin),
        .first_synth_loop_power_o(la), .second_synth_loop_power_o(lb),
        .loop_a_source_select_o(sla), .loop_b_source_select_o(slb),
        .output_enable_o(oe), .output_format_o(fmt),
        .buffered_source_driver_enable_o(ren),
        .buffered_source_driver_format_o(rfmt),
        .buffered_source_driver_select_o(rsel),
        .first_crystal_amp_enable_o(x1), .second_crystal_amp_enable_o(x2));
    assign act = {la, lb, sla, slb, oe, fmt, ren, rfmt, rsel, x1, x2};
    // expected outputs from model registers and pins
    function automatic logic [21:0] model();
        logic pa, pb, ma, mb, ms;
        logic [3:0] e;
        pa = m_c[0] ? m_c[1] : loop_pin_n;
        pb = m_c[2] & m_c[3];
        ma = m_c[4] & m_c[5];
        mb = m_c[6] & m_c[7];
        ms = m_r[27];
        for (int n = 0; n < 4; n++)
            e[n] = (m_c[8+2*n] ? m_c[9+2*n] : en_pin[n]) & (n < 2 ? pa : pb);
        return {pa, pb, ma, mb, e, m_f[7:0], m_c[16] ? m_c[17] : ref_pin,
            m_r[30:29], ms, m_r[26] | !ma | !mb | !ms, m_x[8] | ma | mb | ms};
    endfunction : model
    task automatic check_out(input logic [21:0] exp);
        cmp_count++;
        if (act !== exp) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, exp, act);
        end
    endtask : check_out
    // expected read word: narrow registers in the low bits, pin levels for
    // outputs still under pin control, unmapped words read zero
    function automatic logic [31:0] view(input logic [6:0] idx);
        logic [31:0] v;
        v = '0;
        case (idx)
            clk_cfg_pkg::IDX_CTRL: begin
                v[17:0] = m_c[17:0];
                for (int n = 0; n < 4; n++) begin
                    if (m_c[8+2*n] == 0) begin
                        v[9+2*n] = en_pin[n];
                    end
                end
            end
            clk_cfg_pkg::IDX_REFBUF: v = m_r;
            clk_cfg_pkg::IDX_FMT: v[15:0] = m_f[15:0];
            clk_cfg_pkg::IDX_SECOND_CRYSTAL_FORCE: v[15:0] = m_x[15:0];
            default: ;  // unmapped index reads zero
        endcase
        return v;
    endfunction : view
    // one host read, compared with the model's register view
    task automatic check_rd(input logic [6:0] idx);
        logic [31:0] q;
        i_host.frame(1'b1, idx, 32'h0000_0000, q);
        cmp_count++;
        if (q !== view(idx)) begin
            n_errors++;
            $display("[FAIL] %0t exp %h got %h", $time, view(idx), q);
        end
    endtask : check_rd
    // model registers take the fuse image, as after reset or master reset
    task automatic load_fuses();
        m_c = fuse_c;
        m_r = fuse_r;
        m_f = fuse_f;
        m_x = fuse_x;
    endtask : load_fuses
    // one host write, then the model follows and outputs are compared
    task automatic put(input logic [6:0] idx, input logic [31:0] d);
        logic [31:0] q;
        i_host.frame(1'b0, idx, d, q);
        case (idx)
            clk_cfg_pkg::IDX_CTRL: m_c = d;
            clk_cfg_pkg::IDX_REFBUF: m_r = d;
            clk_cfg_pkg::IDX_FMT: m_f = d;
            clk_cfg_pkg::IDX_SECOND_CRYSTAL_FORCE: m_x = d;
            default: ;  // unmapped index leaves everything alone
        endcase
        // both reset bits in one control write reload the fuse image
        if (idx == clk_cfg_pkg::IDX_CTRL && d[clk_cfg_pkg::MR_EN_BIT] &&
            d[clk_cfg_pkg::MR_BIT]) begin
            load_fuses();
        end
        check_out(model());
    endtask : put
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // hang guard, well above the roughly 40000 cycles the run needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        void'($urandom(46222));
        reset_n_i = 1'b0;
        fuse_c = 24'($urandom);
        fuse_r = $urandom;
        fuse_f = 16'($urandom);
        fuse_x = 16'($urandom);
        {loop_pin_n, ref_pin, en_pin} = 6'($urandom);
        repeat (11) @(negedge clk_i);
        check_out(22'h0);
        @(negedge clk_i) reset_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        load_fuses();
        check_out(model());
        check_rd(clk_cfg_pkg::IDX_CTRL);
        for (int i = 0; i < 16; i++) begin
            if (i == 8) i_host.half = 5;  // slow host for the second half
            {loop_pin_n, ref_pin, en_pin} = 6'($urandom);
            repeat (3) @(negedge clk_i);
            check_out(model());
            // selects walk all 16 codes, master reset bit kept clear
            put(clk_cfg_pkg::IDX_CTRL, ($urandom & 32'h0007_ff0f) | (i << 4));
            put(clk_cfg_pkg::IDX_FMT, {8'($urandom), {4{i[1:0]}}});
            // force bits set only when i mod 4 is 2, otherwise clear
            put(clk_cfg_pkg::IDX_REFBUF, ($urandom & 32'hf3ff_ffff) |
                (i[3] << 27) | ((i % 4 == 2) << 26));
            put(clk_cfg_pkg::IDX_SECOND_CRYSTAL_FORCE, ($urandom & 32'hfeff) |
                ((i % 4 == 2) << 8));
            put(7'h05, $urandom);
            check_rd(clk_cfg_pkg::IDX_CTRL);
            case (i % 4)
                0: check_rd(clk_cfg_pkg::IDX_REFBUF);
                1: check_rd(clk_cfg_pkg::IDX_FMT);
                2: check_rd(clk_cfg_pkg::IDX_SECOND_CRYSTAL_FORCE);
                default: check_rd(7'h05);
            endcase
        end
        // reset bit without its enable is an ordinary write, with it a reload
        put(clk_cfg_pkg::IDX_CTRL, 32'h0008_0000);
        put(clk_cfg_pkg::IDX_CTRL, 32'h000c_0000);
        check_rd(clk_cfg_pkg::IDX_CTRL);
        close_out();
    end
endmodule : clock_ref_output_config_tb
